// ---- verilog/tmc_timer.sv ----
// How it works
// - bit 7 gates match B request
// - bit 6 gates match A request
// - bit 5 gates wrap request
// - capture channel never raises requests
// - bits 4:3 pick counter clear source
// - clock select zero stops counting
// - channel zero prescale taps, refine bit 0
// - channel one prescale taps, refine bit 1
// - channel zero counts channel one wraps
// - channel one counts channel zero match A events
// - mutual cascade gives neither any clock
// - aux channel taps four, 256, 2048
// - capture channel taps one, two, four
// - codes 101-111 count external edges
// - equality sets match flags, constant write suppresses
// - wrap from ff to 00 sets flag
// - flag clears by read one, write zero
`timescale 1ns/100ps
`default_nettype none
module tmc_timer import tmc_pkg::*; #(
  parameter int CHANNELS = NUM_CH
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external clock and reset pins, one pair per channel
  input wire logic [CHANNELS-1:0] extClock,
  input wire logic [CHANNELS-1:0] extReset,
  // interrupt requests, levels
  output logic [CHANNELS-1:0] matchAReq,
  output logic [CHANNELS-1:0] matchBReq,
  output logic [CHANNELS-1:0] wrapReq
);
  // channel-to-tap decode; the prescaler taps mark falling edges of the divided clock
  function automatic logic chanTick(input int ch, input tmc_cks_t cks, input logic [1:0] refine,
                                    input logic [PRESCALE_W-1:0] tick, input tmc_edge_t ext,
                                    input logic cascadeIn);
    logic t;
    t = 1'b0;
    unique case (cks)
      CKS_STOP: t = 1'b0;
      CKS_INT1: begin
        if (ch == CH_ZERO) t = refine[CH_ZERO] ? tick[TAP_DIV2] : tick[TAP_DIV8];
        else if (ch == CH_ONE) t = refine[CH_ONE] ? tick[TAP_DIV2] : tick[TAP_DIV8];
        else if (ch == CH_AUX) t = tick[TAP_DIV4];
        else t = 1'b1;
      end
      CKS_INT2: begin
        if (ch == CH_ZERO) t = refine[CH_ZERO] ? tick[TAP_DIV32] : tick[TAP_DIV64];
        else if (ch == CH_ONE) t = refine[CH_ONE] ? tick[TAP_DIV128] : tick[TAP_DIV64];
        else if (ch == CH_AUX) t = tick[TAP_DIV256];
        else t = tick[TAP_DIV2];
      end
      CKS_INT3: begin
        if (ch == CH_ZERO) t = refine[CH_ZERO] ? tick[TAP_DIV256] : tick[TAP_DIV1024];
        else if (ch == CH_ONE) t = refine[CH_ONE] ? tick[TAP_DIV2048] : tick[TAP_DIV1024];
        else if (ch == CH_AUX) t = tick[TAP_DIV2048];
        else t = tick[TAP_DIV4];
      end
      // only the cascaded pair has a cascade source; others stop
      CKS_CASCADE: t = (ch == CH_ZERO || ch == CH_ONE) ? cascadeIn : 1'b0;
      CKS_EXT_RISE: t = ext.rise;
      CKS_EXT_FALL: t = ext.fall;
      CKS_EXT_BOTH: t = ext.rise | ext.fall;
    endcase
    return t;
  endfunction : chanTick

  function automatic logic isChan(input logic [ADDR_W-1:0] a);
    return a < OFF_SERIAL_TIMER;
  endfunction : isChan

  function automatic logic [CH_SEL_W-1:0] chanOf(input logic [ADDR_W-1:0] a);
    return a[CH_SHIFT +: CH_SEL_W];
  endfunction : chanOf

  function automatic logic [7:0] regOf(input logic [ADDR_W-1:0] a);
    return a & REG_MASK;
  endfunction : regOf

  logic [PRESCALE_W-1:0] tick;
  tmc_edge_t extClkEdge [CHANNELS];
  tmc_edge_t extRstEdge [CHANNELS];

  tmc_prescaler #(.WIDTH(PRESCALE_W)) u_prescaler (
    .clk(clk),
    .reset(reset),
    .tick(tick)
  );

  // per-channel state
  tmc_ctrl_t ctrl_q [CHANNELS];
  tmc_ctrl_t ctrl_d [CHANNELS];
  logic [7:0] cnt_q [CHANNELS];
  logic [7:0] cnt_d [CHANNELS];
  logic [7:0] constA_q [CHANNELS];
  logic [7:0] constA_d [CHANNELS];
  logic [7:0] constB_q [CHANNELS];
  logic [7:0] constB_d [CHANNELS];
  tmc_flags_t flags_q [CHANNELS];
  tmc_flags_t flags_d [CHANNELS];
  tmc_flags_t armed_q [CHANNELS];
  tmc_flags_t armed_d [CHANNELS];
  logic [CHANNELS-1:0] eqA_q, eqA_d, eqB_q, eqB_d;
  logic [CHANNELS-1:0] matchAReq_q, matchAReq_d;
  logic [CHANNELS-1:0] matchBReq_q, matchBReq_d;
  logic [CHANNELS-1:0] wrapReq_q, wrapReq_d;
  logic [CHANNELS-1:0] matchAEvt, matchBEvt, countEn, clearEvt, wrapEvt, cascadeIn;

  // apb state
  logic [1:0] refine_q, refine_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic wrEn, rdDone, cascadeLoop;

  // the access phase always lasts one cycle: data and answer are prepared at setup
  assign wrEn = psel & penable & pready_q & pwrite & ~pslverr_q;
  assign rdDone = psel & penable & pready_q & ~pwrite & ~pslverr_q;

  always_comb begin
    pready_d = psel & ~penable;
    pslverr_d = 1'b0;
    prdata_d = '0;
    refine_d = refine_q;
    if (psel && !penable) begin
      if (paddr == OFF_SERIAL_TIMER) begin
        prdata_d = 32'(refine_q);
      end else if (isChan(paddr) && 32'(chanOf(paddr)) < CHANNELS) begin
        unique case (regOf(paddr))
          OFF_CONTROL: prdata_d = 32'(ctrl_q[chanOf(paddr)]);
          OFF_STATUS: prdata_d = 32'(flags_q[chanOf(paddr)]) << STATUS_FLAG_LSB;
          OFF_COUNTER: prdata_d = 32'(cnt_q[chanOf(paddr)]);
          OFF_CONST_A: prdata_d = 32'(constA_q[chanOf(paddr)]);
          OFF_CONST_B: prdata_d = 32'(constB_q[chanOf(paddr)]);
          default: pslverr_d = 1'b1;
        endcase
      end else begin
        pslverr_d = 1'b1;
      end
    end
    if (wrEn && paddr == OFF_SERIAL_TIMER) begin
      refine_d = pwdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      refine_q <= '0;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      refine_q <= refine_d;
    end
  end

  // a mutual cascade would need each counter to wait on the other
  assign cascadeLoop = ctrl_q[CH_ZERO].clockSelect == CKS_CASCADE &&
                       ctrl_q[CH_ONE].clockSelect == CKS_CASCADE;
  assign cascadeIn[CH_ZERO] = wrapEvt[CH_ONE];
  assign cascadeIn[CH_ONE] = matchAEvt[CH_ZERO];

  for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
    logic hit, suppressA, suppressB, eqA, eqB;

    if (g > CH_ONE) begin : g_nocas
      assign cascadeIn[g] = 1'b0;
    end

    tmc_pin_sync u_clk_sync (
      .clk(clk),
      .reset(reset),
      .pin(extClock[g]),
      .edges(extClkEdge[g])
    );

    tmc_pin_sync u_rst_sync (
      .clk(clk),
      .reset(reset),
      .pin(extReset[g]),
      .edges(extRstEdge[g])
    );

    assign hit = isChan(paddr) && 32'(chanOf(paddr)) == g;
    // no compare while its constant is being written
    assign suppressA = wrEn && hit && regOf(paddr) == OFF_CONST_A;
    assign suppressB = wrEn && hit && regOf(paddr) == OFF_CONST_B;
    assign eqA = cnt_q[g] == constA_q[g] && !suppressA;
    assign eqB = cnt_q[g] == constB_q[g] && !suppressB;
    assign matchAEvt[g] = eqA & ~eqA_q[g];
    assign matchBEvt[g] = eqB & ~eqB_q[g];
    assign countEn[g] = (g <= CH_ONE && cascadeLoop) ? 1'b0 :
                        chanTick(g, ctrl_q[g].clockSelect, refine_q, tick,
                                 extClkEdge[g], cascadeIn[g]);
    always_comb begin
      unique case (ctrl_q[g].clearSelect)
        CLR_NEVER: clearEvt[g] = 1'b0;
        CLR_MATCH_A: clearEvt[g] = matchAEvt[g];
        CLR_MATCH_B: clearEvt[g] = matchBEvt[g];
        CLR_EXT: clearEvt[g] = extRstEdge[g].rise;
      endcase
    end
    assign wrapEvt[g] = countEn[g] && cnt_q[g] == MAX_COUNT && !clearEvt[g];

    always_comb begin
      tmc_flags_t setF;
      tmc_flags_t clrF;
      setF = '{matchB: matchBEvt[g], matchA: matchAEvt[g], wrap: wrapEvt[g]};
      clrF = '0;
      ctrl_d[g] = ctrl_q[g];
      cnt_d[g] = cnt_q[g];
      constA_d[g] = constA_q[g];
      constB_d[g] = constB_q[g];
      armed_d[g] = armed_q[g];
      if (clearEvt[g]) cnt_d[g] = COUNTER_RESET;
      else if (countEn[g]) cnt_d[g] = cnt_q[g] + 8'h01;
      if (rdDone && hit && regOf(paddr) == OFF_STATUS) begin
        armed_d[g] = armed_q[g] | flags_q[g];
      end
      if (wrEn && hit) begin
        unique case (regOf(paddr))
          OFF_CONTROL: ctrl_d[g] = tmc_ctrl_t'(pwdata[7:0]);
          OFF_COUNTER: cnt_d[g] = pwdata[7:0];
          OFF_CONST_A: constA_d[g] = pwdata[7:0];
          OFF_CONST_B: constB_d[g] = pwdata[7:0];
          OFF_STATUS: begin
            // writing one leaves a flag alone; zero clears only an armed flag
            clrF = armed_q[g] & ~tmc_flags_t'(pwdata[STATUS_FLAG_LSB +: 3]);
            armed_d[g] = '0;
          end
          default: ;
        endcase
      end
      flags_d[g] = (flags_q[g] & ~clrF) | setF;
      eqA_d[g] = eqA;
      eqB_d[g] = eqB;
      // the capture channel's request lines are always held low
      matchBReq_d[g] = g != CH_CAPTURE && flags_q[g].matchB && ctrl_q[g].matchBIrqEnable;
      matchAReq_d[g] = g != CH_CAPTURE && flags_q[g].matchA && ctrl_q[g].matchAIrqEnable;
      wrapReq_d[g] = g != CH_CAPTURE && flags_q[g].wrap && ctrl_q[g].wrapIrqEnable;
    end

    always_ff @(posedge clk) begin
      if (reset) begin
        ctrl_q[g] <= tmc_ctrl_t'(CONTROL_RESET);
        cnt_q[g] <= COUNTER_RESET;
        constA_q[g] <= CONST_RESET;
        constB_q[g] <= CONST_RESET;
        flags_q[g] <= '0;
        armed_q[g] <= '0;
        eqA_q[g] <= 1'b0;
        eqB_q[g] <= 1'b0;
        matchAReq_q[g] <= 1'b0;
        matchBReq_q[g] <= 1'b0;
        wrapReq_q[g] <= 1'b0;
      end else begin
        ctrl_q[g] <= ctrl_d[g];
        cnt_q[g] <= cnt_d[g];
        constA_q[g] <= constA_d[g];
        constB_q[g] <= constB_d[g];
        flags_q[g] <= flags_d[g];
        armed_q[g] <= armed_d[g];
        eqA_q[g] <= eqA_d[g];
        eqB_q[g] <= eqB_d[g];
        matchAReq_q[g] <= matchAReq_d[g];
        matchBReq_q[g] <= matchBReq_d[g];
        wrapReq_q[g] <= wrapReq_d[g];
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign matchAReq = matchAReq_q;
  assign matchBReq = matchBReq_q;
  assign wrapReq = wrapReq_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_match_b_req: assert property (flags_q[CH_ZERO].matchB
    && ctrl_q[CH_ZERO].matchBIrqEnable |=> matchBReq[CH_ZERO])
    else $error("match b request missing");
  a_match_a_req: assert property (matchAReq[CH_ONE]
    |-> $past(flags_q[CH_ONE].matchA) && $past(ctrl_q[CH_ONE].matchAIrqEnable))
    else $error("match a request without cause");
  a_wrap_req_gate: assert property (!ctrl_q[CH_AUX].wrapIrqEnable
    ##1 !ctrl_q[CH_AUX].wrapIrqEnable |-> !wrapReq[CH_AUX])
    else $error("wrap request while disabled");
  a_capture_silent: assert property (!matchAReq[CH_CAPTURE]
    && !matchBReq[CH_CAPTURE] && !wrapReq[CH_CAPTURE])
    else $error("capture channel raised a request");
  a_clear_on_a: assert property (ctrl_q[CH_ZERO].clearSelect == CLR_MATCH_A
    && matchAEvt[CH_ZERO] && !(wrEn && g_ch[CH_ZERO].hit)
    |=> cnt_q[CH_ZERO] == COUNTER_RESET) else $error("counter not cleared on match a");
  a_stop_holds: assert property (ctrl_q[CH_AUX].clockSelect == CKS_STOP
    && !clearEvt[CH_AUX] && !wrEn |=> $stable(cnt_q[CH_AUX]))
    else $error("stopped counter moved");
  a_zero_tap: assert property (ctrl_q[CH_ZERO].clockSelect == CKS_INT1
    && !refine_q[CH_ZERO] |-> countEn[CH_ZERO] == tick[TAP_DIV8])
    else $error("channel zero tap wrong");
  a_refine_tap: assert property (ctrl_q[CH_ONE].clockSelect == CKS_INT2
    && refine_q[CH_ONE] |-> countEn[CH_ONE] == tick[TAP_DIV128])
    else $error("channel one tap wrong");
  a_wrap_cascade: assert property (ctrl_q[CH_ZERO].clockSelect == CKS_CASCADE
    && !cascadeLoop |-> countEn[CH_ZERO] == wrapEvt[CH_ONE])
    else $error("channel zero missed a cascade wrap");
  a_cascade_loop: assert property (cascadeLoop
    |-> !countEn[CH_ZERO] && !countEn[CH_ONE])
    else $error("mutual cascade produced a count");
  a_aux_tap: assert property (ctrl_q[CH_AUX].clockSelect == CKS_INT3
    |-> countEn[CH_AUX] == tick[TAP_DIV2048])
    else $error("aux channel tap wrong");
  a_capture_full: assert property (ctrl_q[CH_CAPTURE].clockSelect == CKS_INT1
    && !clearEvt[CH_CAPTURE] && !wrEn |=> cnt_q[CH_CAPTURE] == $past(cnt_q[CH_CAPTURE]) + 8'h01)
    else $error("undivided count missed");
  a_compare_hold: assert property (wrEn && g_ch[CH_AUX].hit
    && regOf(paddr) == OFF_CONST_A |-> !matchAEvt[CH_AUX])
    else $error("compare ran during constant write");
  a_wrap_flag: assert property (wrapEvt[CH_ZERO]
    |=> flags_q[CH_ZERO].wrap && cnt_q[CH_ZERO] != MAX_COUNT)
    else $error("wrap flag not set");
  a_flag_clear: assert property ($fell(flags_q[CH_ZERO].wrap)
    |-> $past(wrEn) && $past(armed_q[CH_ZERO].wrap))
    else $error("flag cleared unarmed");
  a_ext_rise: assert property (ctrl_q[CH_AUX].clockSelect == CKS_EXT_RISE
    |-> countEn[CH_AUX] == extClkEdge[CH_AUX].rise)
    else $error("external edge count wrong");
  a_request_drop: assert property (!flags_q[CH_ONE].wrap
    |=> !wrapReq[CH_ONE])
    else $error("wrap request outlived its flag");
endmodule : tmc_timer
`default_nettype wire

// ---- verilog/tmc_pkg.sv ----
`default_nettype none
package tmc_pkg;
  // channel indices
  localparam int NUM_CH = 4;
  localparam int CH_ZERO = 0;
  localparam int CH_ONE = 1;
  localparam int CH_CAPTURE = 2;
  localparam int CH_AUX = 3;
  // register map, one aligned word each, channel block every 32 bytes
  localparam int ADDR_W = 8;
  localparam int CH_SHIFT = 5;
  localparam int CH_SEL_W = 2;
  localparam logic [7:0] REG_MASK = 8'h1f;
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_COUNTER = 8'h08;
  localparam logic [7:0] OFF_CONST_A = 8'h0c;
  localparam logic [7:0] OFF_CONST_B = 8'h10;
  localparam logic [7:0] OFF_SERIAL_TIMER = 8'h80;
  // reset values and limits
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] COUNTER_RESET = 8'h00;
  localparam logic [7:0] CONST_RESET = 8'hff;
  localparam logic [7:0] MAX_COUNT = 8'hff;
  localparam int STATUS_FLAG_LSB = 5;
  // prescaler: tick[i] marks a falling edge of clk divided by 2**(i+1)
  localparam int PRESCALE_W = 11;
  localparam int TAP_DIV2 = 0;
  localparam int TAP_DIV4 = 1;
  localparam int TAP_DIV8 = 2;
  localparam int TAP_DIV32 = 4;
  localparam int TAP_DIV64 = 5;
  localparam int TAP_DIV128 = 6;
  localparam int TAP_DIV256 = 7;
  localparam int TAP_DIV1024 = 9;
  localparam int TAP_DIV2048 = 10;

  typedef enum logic [2:0] {
    CKS_STOP = 3'h0, CKS_INT1 = 3'h1, CKS_INT2 = 3'h2, CKS_INT3 = 3'h3,
    CKS_CASCADE = 3'h4, CKS_EXT_RISE = 3'h5, CKS_EXT_FALL = 3'h6, CKS_EXT_BOTH = 3'h7
  } tmc_cks_t;

  typedef enum logic [1:0] {
    CLR_NEVER = 2'h0, CLR_MATCH_A = 2'h1, CLR_MATCH_B = 2'h2, CLR_EXT = 2'h3
  } tmc_clr_t;

  // timer_control layout, bit 7 down to bit 0
  typedef struct packed {
    logic matchBIrqEnable;
    logic matchAIrqEnable;
    logic wrapIrqEnable;
    tmc_clr_t clearSelect;
    tmc_cks_t clockSelect;
  } tmc_ctrl_t;

  typedef struct packed {
    logic matchB;
    logic matchA;
    logic wrap;
  } tmc_flags_t;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } tmc_edge_t;
endpackage : tmc_pkg
`default_nettype wire

// ---- verilog/tmc_prescaler.sv ----
`timescale 1ns/100ps
`default_nettype none
module tmc_prescaler import tmc_pkg::*; #(
  parameter int WIDTH = PRESCALE_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // one-cycle strobes at each falling edge of a divided clock
  output logic [WIDTH-1:0] tick
);
  logic [WIDTH-1:0] div_q, div_d;
  logic [WIDTH-1:0] tick_q, tick_d;

  always_comb begin
    logic ones;
    ones = 1'b1;
    div_d = div_q + 1'b1;
    for (int i = 0; i < WIDTH; i++) begin
      // bit i falls exactly when bits i..0 roll over from all ones
      ones = ones & div_q[i];
      tick_d[i] = ones;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      div_q <= '0;
      tick_q <= '0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule : tmc_prescaler
`default_nettype wire

// ---- verilog/tmc_pin_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module tmc_pin_sync import tmc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // asynchronous pin
  input wire logic pin,
  // filtered level and one-cycle edge strobes
  output tmc_edge_t edges
);
  logic s1_q, s2_q, s3_q;
  logic level_q, level_d;
  logic agree;

  // a change counts only once the second and third stages agree
  assign agree = (s2_q == s3_q);

  always_comb begin
    level_d = agree ? s3_q : level_q;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end

  assign edges.level = level_q;
  assign edges.rise = agree & s3_q & ~level_q;
  assign edges.fall = agree & ~s3_q & level_q;
endmodule : tmc_pin_sync
`default_nettype wire

// ---- tb/tmc_timer_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module tmc_timer_bench import tmc_pkg::*;;
  // the tap passes dominate; the whole run needs about 30000 cycles
  localparam int LIMIT = 60000;
  localparam int DIVS [4][2][4] = '{'{'{0, 8, 64, 1024}, '{0, 2, 32, 256}},
    '{'{0, 8, 64, 1024}, '{0, 2, 128, 2048}}, '{'{0, 1, 2, 4}, '{0, 1, 2, 4}},
    '{'{0, 4, 256, 2048}, '{0, 4, 256, 2048}}};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NUM_CH-1:0] extClock = '0;
  logic [NUM_CH-1:0] extReset = '0;
  logic [NUM_CH-1:0] matchAReq;
  logic [NUM_CH-1:0] matchBReq;
  logic [NUM_CH-1:0] wrapReq;
  int nErrors = 0;
  int checksDone = 0;
  int cycles = 0;
  logic [31:0] v;
  logic e;
  int dv;

  tmc_timer tmc_timer_i (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .extClock(extClock), .extReset(extReset), .matchAReq(matchAReq),
    .matchBReq(matchBReq), .wrapReq(wrapReq));

  always #2.5 clk = ~clk;

  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : reportAndStop

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      nErrors++;
      reportAndStop();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nErrors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // starts one edge late so back-to-back calls never assign psel twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      check("pready", 32'(pready), 32'h1);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wrA(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic x;
    apb(1'b1, a, d, r, x);
  endtask : wrA

  task automatic rdA(input logic [7:0] a, output logic [31:0] d);
    logic x;
    apb(1'b0, a, 32'h0, d, x);
  endtask : rdA

  function automatic logic [7:0] ad(input int ch, input logic [7:0] off);
    return 8'(ch << CH_SHIFT) | off;
  endfunction : ad

  function automatic logic [31:0] inSpan(input logic [31:0] x, input int lo, input int hi);
    return {31'h0, x >= lo && x <= hi};
  endfunction : inSpan

  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      apb(1'b0, ad(ch, OFF_CONTROL), 32'h0, v, e);
      check("control reset", v, 32'h0);
      check("mapped error", {31'h0, e}, 32'h0);
      rdA(ad(ch, OFF_COUNTER), v);
      check("counter reset", v, 32'h0);
      rdA(ad(ch, OFF_CONST_B), v);
      check("constant reset", v, 32'hff);
      rdA(ad(ch, OFF_STATUS), v);
      check("flags reset", v & 32'he0, 32'h0);
    end
    apb(1'b0, 8'h14, 32'h0, v, e);
    check("unmapped error", {31'h0, e}, 32'h1);
    check("unmapped data", v, 32'h0);
    wrA(ad(1, OFF_CONTROL), 32'hffff_ff5a);
    rdA(ad(1, OFF_CONTROL), v);
    check("control readback", v, 32'h5a);
    wrA(ad(1, OFF_CONTROL), 32'h0);
    $display("test registers done");
    for (int ch = 0; ch < NUM_CH; ch++) begin
      for (int r = 0; r < 2; r++) begin
        for (int code = 0; code < 5; code++) begin
          if ((r == 1 && ch > 1) || (code == 4 && ch < 2)) continue;
          dv = code > 3 ? 0 : DIVS[ch][r][code];
          wrA(OFF_SERIAL_TIMER, 32'(r * 3));
          wrA(ad(ch, OFF_CONTROL), 32'(code));
          wrA(ad(ch, OFF_COUNTER), 32'h0);
          // four ticks expected; tap phase leaves one tick of slack
          repeat (dv > 0 ? 4 * dv : 64) @(posedge clk);
          rdA(ad(ch, OFF_COUNTER), v);
          if (dv == 0) check("stopped count", v, 32'h0);
          else check("tap count", inSpan(v, 3, 5), 32'h1);
          wrA(ad(ch, OFF_CONTROL), 32'h0);
        end
      end
    end
    $display("test taps done");
    wrA(ad(2, OFF_CONST_A), 32'h3);
    wrA(ad(2, OFF_CONST_B), 32'h6);
    for (int m = 0; m < 3; m++) begin
      wrA(ad(2, OFF_CONTROL), 32'((m << 3) | 1));
      wrA(ad(2, OFF_COUNTER), 32'h0);
      repeat (40) @(posedge clk);
      rdA(ad(2, OFF_COUNTER), v);
      check("clear select", inSpan(v, m == 0 ? 30 : 0, m == 0 ? 50 : 3 * m), 32'h1);
    end
    wrA(ad(2, OFF_CONTROL), 32'h19);
    wrA(ad(2, OFF_COUNTER), 32'h0);
    repeat (100) @(posedge clk);
    extReset[2] <= 1'b1;
    repeat (10) @(posedge clk);
    rdA(ad(2, OFF_COUNTER), v);
    check("pin clear", inSpan(v, 0, 15), 32'h1);
    extReset[2] <= 1'b0;
    wrA(ad(2, OFF_CONTROL), 32'h0);
    $display("test clear done");
    wrA(OFF_SERIAL_TIMER, 32'h3);
    wrA(ad(0, OFF_CONST_A), 32'h3);
    wrA(ad(1, OFF_CONTROL), 32'h4);
    wrA(ad(1, OFF_COUNTER), 32'h0);
    // channel zero still holds its last tap count, above the constant
    wrA(ad(0, OFF_COUNTER), 32'h0);
    wrA(ad(0, OFF_CONTROL), 32'h9);
    repeat (80) @(posedge clk);
    rdA(ad(1, OFF_COUNTER), v);
    check("match cascade", inSpan(v, 8, 15), 32'h1);
    rdA(ad(0, OFF_COUNTER), v);
    check("match a clear", inSpan(v, 0, 3), 32'h1);
    wrA(ad(0, OFF_CONTROL), 32'h4);
    wrA(ad(0, OFF_COUNTER), 32'h0);
    wrA(ad(1, OFF_COUNTER), 32'h0);
    // a fresh match on channel zero would count on channel one without the loop guard
    wrA(ad(0, OFF_COUNTER), 32'h3);
    repeat (40) @(posedge clk);
    rdA(ad(0, OFF_COUNTER), v);
    check("mutual zero", v, 32'h3);
    rdA(ad(1, OFF_COUNTER), v);
    check("mutual one", v, 32'h0);
    wrA(ad(1, OFF_COUNTER), 32'hfc);
    wrA(ad(1, OFF_CONTROL), 32'h1);
    repeat (30) @(posedge clk);
    rdA(ad(0, OFF_COUNTER), v);
    check("wrap cascade", v, 32'h4);
    rdA(ad(1, OFF_STATUS), v);
    check("wrap flag", v & 32'h20, 32'h20);
    wrA(ad(0, OFF_CONTROL), 32'h0);
    wrA(ad(1, OFF_CONTROL), 32'h0);
    $display("test cascade done");
    for (int code = 5; code < 8; code++) begin
      wrA(ad(0, OFF_CONTROL), 32'(code));
      wrA(ad(0, OFF_COUNTER), 32'h0);
      for (int k = 0; k < 4; k++) begin
        extClock[0] <= 1'b1;
        repeat (10) @(posedge clk);
        extClock[0] <= 1'b0;
        repeat (10) @(posedge clk);
      end
      rdA(ad(0, OFF_COUNTER), v);
      check("pin edges", v, code == 7 ? 32'h8 : 32'h4);
    end
    wrA(ad(0, OFF_CONTROL), 32'h0);
    $display("test pin clock done");
    for (int ch = 2; ch < 4; ch++) begin
      wrA(ad(ch, OFF_CONST_A), 32'h2);
      wrA(ad(ch, OFF_CONST_B), 32'h4);
      wrA(ad(ch, OFF_COUNTER), 32'hfe);
      wrA(ad(ch, OFF_CONTROL), 32'h1);
    end
    repeat (80) @(posedge clk);
    for (int ch = 2; ch < 4; ch++) begin
      wrA(ad(ch, OFF_CONTROL), 32'h0);
      rdA(ad(ch, OFF_STATUS), v);
      check("flags set", v & 32'he0, 32'he0);
      // ones must not clear; a zero without a fresh read must not clear either
      wrA(ad(ch, OFF_STATUS), 32'he0);
      wrA(ad(ch, OFF_STATUS), 32'h0);
      rdA(ad(ch, OFF_STATUS), v);
      check("flags held", v & 32'he0, 32'he0);
    end
    for (int b = 5; b < 8; b++) begin
      wrA(ad(2, OFF_CONTROL), 32'(1 << b));
      wrA(ad(3, OFF_CONTROL), 32'(1 << b));
      repeat (3) @(posedge clk);
      check("match b request", 32'(matchBReq), b == 7 ? 32'h8 : 32'h0);
      check("match a request", 32'(matchAReq), b == 6 ? 32'h8 : 32'h0);
      check("wrap request", 32'(wrapReq), b == 5 ? 32'h8 : 32'h0);
    end
    wrA(ad(2, OFF_CONTROL), 32'he0);
    wrA(ad(3, OFF_CONTROL), 32'he0);
    repeat (3) @(posedge clk);
    check("all requests", 32'({matchBReq, matchAReq, wrapReq}), 32'h888);
    for (int ch = 2; ch < 4; ch++) begin
      rdA(ad(ch, OFF_STATUS), v);
      wrA(ad(ch, OFF_STATUS), 32'h0);
      rdA(ad(ch, OFF_STATUS), v);
      check("flags cleared", v & 32'he0, 32'h0);
    end
    repeat (3) @(posedge clk);
    check("requests dropped", 32'({matchBReq, matchAReq, wrapReq}), 32'h0);
    $display("test requests done");
    reportAndStop();
  end
endmodule : tmc_timer_bench
`default_nettype wire
